// ---- shared/second_operand_shifter_regs.vh ----
// constants for the second operand shifter
`ifndef SECOND_OPERAND_SHIFTER_REGS_VH
`define SECOND_OPERAND_SHIFTER_REGS_VH
// shift type codes
`define SHIFT_LSL_CODE   3'h0
`define SHIFT_LSR_CODE   3'h1
`define SHIFT_ASR_CODE   3'h2
`define SHIFT_ROR_CODE   3'h3
`define SHIFT_RRX_CODE   3'h4
// immediate form codes
`define IMM_SHIFTED      2'h0
`define IMM_REP_LOW      2'h1
`define IMM_REP_HIGH     2'h2
`define IMM_REP_ALL      2'h3
// largest plain byte immediate
`define IMM_BYTE_MAX     32'h000000FF
// byte lanes of a replicated immediate
`define IMM_LANES        4
// shift length limits
`define SHIFT_LEN_ZERO   6'h00
`define SHIFT_LEN_ONE    6'h01
`define SHIFT_LEN_WORD   6'h20
// reset values of the result register
`define RST_OPERAND      32'h00000000
`define RST_FLAG         1'h0
`endif

// ---- hdl/second_operand_shifter.v ----
// second operand preparation stage: immediate expander and register shifter
`timescale 1ns/1ps
`include "second_operand_shifter_regs.vh"

// Behaviour
// - operand is either expanded immediate or shifted source register
// - immediate may be an 8-bit value shifted left anywhere in 32 bits
// - immediate may be byte-replicated 0x00XY00XY, 0xXY00XY00 or 0xXYXYXYXY
// - flag-setting logical ops: shifted immediate above 255 sets carry to bit 31
// - other immediate forms leave carry unchanged for those ops
// - arithmetic and logical shift right support lengths 1 through 32
// - logical shift left and rotate right support lengths 1 through 31
// - rotate right with extend takes no length
// - no shift or left shift by zero passes source unmodified
// - shifted result is 32 bits; source register is untouched
// - arithmetic right fills with sign; length 32 or more gives all sign bits
// - carry is bit n-1 for right shifts and rotates, bit 32-n for left
// - extend rotate inserts carry at bit 31, carry out is bit 0
// - zero length never shifts and never changes carry, except extend rotate, which ignores the length
module second_operand_shifter
(
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // request
   input  wire        valid_i,
   input  wire        use_imm_i,
   input  wire [1:0]  imm_form_i,
   input  wire [7:0]  imm_byte_i,
   input  wire [4:0]  imm_pos_i,
   input  wire [31:0] shift_source_register_i,
   input  wire [2:0]  shift_type_i,
   input  wire [5:0]  shift_len_i,
   input  wire        sets_flags_i,
   input  wire        carry_i,
   // result
   output reg         valid_o,
   output reg  [31:0] flexible_second_operand_o,
   output reg         carry_o,
   output reg         carry_updated_o
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // one bit of a word by a 6-bit index; an index of 32 or more reads zero
   function pick_bit;
      input [31:0] value;
      input [5:0]  index;
   begin
      pick_bit = 1'h0;
      if (index < `SHIFT_LEN_WORD)
      begin
         pick_bit = value[index[4:0]];
      end
   end
   endfunction

   // byte lane enable of the replicated immediate forms
   // lanes 0 and 2 for the low pattern, 1 and 3 for the high one
   function rep_lane_on;
      input [1:0]   form;
      input integer lane;
   begin
      case (form)
         `IMM_REP_LOW:  rep_lane_on = ((lane % 2) == 0);
         `IMM_REP_HIGH: rep_lane_on = ((lane % 2) == 1);
         `IMM_REP_ALL:  rep_lane_on = 1'h1;
         default:       rep_lane_on = 1'h0;
      endcase
   end
   endfunction

   // ----------------------------------------------------------------
   // immediate expander
   // ----------------------------------------------------------------
   wire [31:0] shifted_imm;
   wire [31:0] rep_value;
   wire        imm_is_shifted;
   wire [31:0] imm_value;
   wire        imm_carry_upd;

   assign shifted_imm    = {24'h000000, imm_byte_i} << imm_pos_i;
   assign imm_is_shifted = (imm_form_i == `IMM_SHIFTED);

   // ----------------------------------------------------------------
   // byte lane replication
   // ----------------------------------------------------------------
   genvar lane;
   generate
      for (lane = 0; lane < `IMM_LANES; lane = lane + 1)
      begin : g_rep_lane
         assign rep_value[8*lane+7:8*lane] = rep_lane_on(imm_form_i, lane) ? imm_byte_i : 8'h00;
      end
   endgenerate

   assign imm_value      = imm_is_shifted ? shifted_imm : rep_value;
   // a plain byte or a replicated pattern leaves carry alone
   assign imm_carry_upd  = imm_is_shifted & (shifted_imm > `IMM_BYTE_MAX);

   // ----------------------------------------------------------------
   // shift length decode
   // ----------------------------------------------------------------
   wire [31:0] src;
   wire        len_zero;
   wire        len_full;
   wire [4:0]  len5;
   wire [5:0]  len_left;
   wire [5:0]  len_less;
   wire [63:0] rot_pair;

   assign src      = shift_source_register_i;
   assign len_zero = (shift_len_i == `SHIFT_LEN_ZERO);
   assign len_full = (shift_len_i >= `SHIFT_LEN_WORD);
   assign len5     = shift_len_i[4:0];
   // carry positions 32-n and n-1; a wrapped position reads zero
   assign len_left = `SHIFT_LEN_WORD - shift_len_i;
   assign len_less = shift_len_i - `SHIFT_LEN_ONE;
   // rotate by the length modulo 32
   assign rot_pair = {src, src} >> len5;

   // ----------------------------------------------------------------
   // register shifter
   // ----------------------------------------------------------------
   reg  [31:0] reg_value;
   reg         reg_carry;
   reg         reg_carry_upd;

   // length shifts skip a zero length entirely
   always @*
   begin
      reg_value     = src;
      reg_carry     = carry_i;
      reg_carry_upd = 1'h0;
      case (shift_type_i)
         `SHIFT_LSL_CODE:
         begin
            if (!len_zero)
            begin
               reg_value     = len_full ? 32'h00000000 : (src << len5);
               reg_carry     = pick_bit(src, len_left);
               reg_carry_upd = 1'h1;
            end
         end
         `SHIFT_LSR_CODE:
         begin
            if (!len_zero)
            begin
               reg_value     = len_full ? 32'h00000000 : (src >> len5);
               reg_carry     = pick_bit(src, len_less);
               reg_carry_upd = 1'h1;
            end
         end
         `SHIFT_ASR_CODE:
         begin
            if (!len_zero)
            begin
               reg_value     = len_full ? {32{src[31]}}
                             : $unsigned($signed(src) >>> len5);
               reg_carry     = len_full ? src[31] : pick_bit(src, len_less);
               reg_carry_upd = 1'h1;
            end
         end
         `SHIFT_ROR_CODE:
         begin
            if (!len_zero)
            begin
               reg_value     = rot_pair[31:0];
               reg_carry     = rot_pair[31];
               reg_carry_upd = 1'h1;
            end
         end
         `SHIFT_RRX_CODE:
         begin
            reg_value     = {carry_i, src[31:1]};
            reg_carry     = src[0];
            reg_carry_upd = 1'h1;
         end
         default:
         begin
            reg_value     = src;
            reg_carry     = carry_i;
            reg_carry_upd = 1'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // operand select and result register
   // ----------------------------------------------------------------
   wire        upd;
   wire        new_carry;
   wire        next_carry;
   wire [31:0] next_operand;

   assign upd          = sets_flags_i & (use_imm_i ? imm_carry_upd : reg_carry_upd);
   assign new_carry    = use_imm_i ? imm_value[31] : reg_carry;
   // non flag-setting work keeps the incoming carry
   assign next_carry   = upd ? new_carry : carry_i;
   assign next_operand = use_imm_i ? imm_value : reg_value;

   // one cycle of latency, a new request every cycle
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         valid_o                   <= `RST_FLAG;
         flexible_second_operand_o <= `RST_OPERAND;
         carry_o                   <= `RST_FLAG;
         carry_updated_o           <= `RST_FLAG;
      end
      else
      begin
         valid_o                   <= valid_i;
         flexible_second_operand_o <= next_operand;
         carry_o                   <= next_carry;
         carry_updated_o           <= upd;
      end
   end

endmodule

// ---- dv/second_operand_shifter_asserts.sv ----
// port checker for the second operand shifter
`timescale 1ns/1ps
module second_operand_shifter_asserts
(
   // clock and reset
   input wire        ref_clk_i,
   input wire        rst_i,
   // request
   input wire        valid_i,
   input wire        use_imm_i,
   input wire [1:0]  imm_form_i,
   input wire [7:0]  imm_byte_i,
   input wire [4:0]  imm_pos_i,
   input wire [31:0] shift_source_register_i,
   input wire [2:0]  shift_type_i,
   input wire [5:0]  shift_len_i,
   input wire        sets_flags_i,
   input wire        carry_i,
   // result
   input wire        valid_o,
   input wire [31:0] flexible_second_operand_o,
   input wire        carry_o,
   input wire        carry_updated_o
);
   logic        live, u, f, c;
   logic [1:0]  m;
   logic [2:0]  t;
   logic [5:0]  n;
   logic [7:0]  b;
   logic [31:0] s, v;
   wire  [31:0] q = flexible_second_operand_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge ref_clk_i or posedge rst_i)
      if (rst_i) live <= 1'h0;
      else live <= 1'h1;
   always_ff @(posedge ref_clk_i)
      {u, f, c, m, t, n, b, s, v} <= {use_imm_i, sets_flags_i, carry_i, imm_form_i, shift_type_i, shift_len_i,
                                      imm_byte_i, shift_source_register_i, {24'h0, imm_byte_i} << imm_pos_i};
   AST_VALID: assert property (live |-> valid_o == $past(valid_i)) else $error("valid lag");
   AST_PASS: assert property (live && !f |-> carry_o == c && !carry_updated_o) else $error("carry pass");
   AST_IMM: assert property (live && u && m == 2'h0 |-> q == v) else $error("imm shift");
   AST_REP: assert property (live && u && m == 2'h1 |-> q == {2{8'h00, b}}) else $error("imm rep");
   AST_IC: assert property (live && u && f && m == 2'h0 && v > 32'hFF |-> carry_o == v[31]) else $error("imm c");
   AST_IK: assert property (live && u && (m != 2'h0 || v <= 32'hFF) |-> carry_o == c) else $error("imm keep");
   AST_ZERO: assert property (live && !u && t < 3'h4 && n == 6'h0 |-> q == s && carry_o == c) else $error("len0");
   AST_RRX: assert property (live && !u && t == 3'h4 |-> q == {c, s[31:1]}) else $error("rrx");
   AST_ASR: assert property (live && !u && t == 3'h2 && n > 6'h1F |-> q == {32{s[31]}}) else $error("asr");
   AST_REP_HI: assert property (live && u && m == 2'h2 |-> q == {2{b, 8'h00}}) else $error("imm rep high");
   AST_REP_ALL: assert property (live && u && m == 2'h3 |-> q == {4{b}}) else $error("imm rep all");
   AST_RRX_C: assert property (live && !u && f && t == 3'h4 |-> carry_o == s[0] && carry_updated_o)
      else $error("rrx carry");
endmodule

// ---- dv/tb_second_operand_shifter.sv ----
// random and corner bench for the second operand shifter
`timescale 1ns/1ps
module tb_second_operand_shifter;
   logic        ref_clk_i = 1'b0, rst_i = 1'b1, valid_i = 1'b0, use_imm_i = 1'b0, sets_flags_i = 1'b0, carry_i = 1'b0;
   logic [1:0]  imm_form_i = 2'h0;
   logic [7:0]  imm_byte_i = 8'h00;
   logic [4:0]  imm_pos_i = 5'h00;
   logic [2:0]  shift_type_i = 3'h0;
   logic [5:0]  shift_len_i = 6'h00;
   logic [31:0] shift_source_register_i = 32'h0, flexible_second_operand_o;
   logic        valid_o, carry_o, carry_updated_o, primed = 1'b0;
   logic [34:0] want;
   logic [63:0] r;
   integer      seed = 32'h846E, bad_count = 0, comparisons = 0, k;
   always #20 ref_clk_i = ~ref_clk_i;
   second_operand_shifter i_dut
   (
      .ref_clk_i                 (ref_clk_i),
      .rst_i                     (rst_i),
      .valid_i                   (valid_i),
      .use_imm_i                 (use_imm_i),
      .imm_form_i                (imm_form_i),
      .imm_byte_i                (imm_byte_i),
      .imm_pos_i                 (imm_pos_i),
      .shift_source_register_i   (shift_source_register_i),
      .shift_type_i              (shift_type_i),
      .shift_len_i               (shift_len_i),
      .sets_flags_i              (sets_flags_i),
      .carry_i                   (carry_i),
      .valid_o                   (valid_o),
      .flexible_second_operand_o (flexible_second_operand_o),
      .carry_o                   (carry_o),
      .carry_updated_o           (carry_updated_o)
   );
   function automatic logic [33:0] model();
      logic [31:0] q, v;
      logic        nc, up;
      logic [64:0] w;
      v = {24'h0, imm_byte_i} << imm_pos_i;
      up = shift_len_i != 6'h0;
      w = {{2{shift_source_register_i}}, shift_source_register_i[31]} >> shift_len_i[4:0];
      case (shift_type_i)
         3'h0: {nc, q} = {1'b0, shift_source_register_i} << shift_len_i;
         3'h1: {q, nc} = {shift_source_register_i, 1'b0} >> shift_len_i;
         3'h2: {q, nc} = $signed({shift_source_register_i, 1'b0}) >>> shift_len_i;
         3'h3: {q, nc} = w[32:0];
         3'h4: {q, nc, up} = {carry_i, shift_source_register_i, 1'b1};
         default: {q, nc, up} = {shift_source_register_i, carry_i, 1'b0};
      endcase
      if (use_imm_i) {q, nc, up} = {imm_form_i == 2'h0 ? v : imm_form_i == 2'h1 ? {2{8'h00, imm_byte_i}} :
         imm_form_i == 2'h2 ? {2{imm_byte_i, 8'h00}} : {4{imm_byte_i}}, v[31], imm_form_i == 2'h0 && v > 32'hFF};
      return {q, up && sets_flags_i ? nc : carry_i, up && sets_flags_i};
   endfunction
   task check(input logic [34:0] got);
      comparisons = comparisons + 1;
      if (got !== want)
      begin
         bad_count = bad_count + 1;
         $display("unexpected outputs: expected %h seen %h", want, got);
      end
   endtask
   task apply(input logic [59:0] v);
      @(posedge ref_clk_i);
      {valid_i, use_imm_i, imm_form_i, imm_byte_i, imm_pos_i, shift_source_register_i, shift_type_i, shift_len_i,
       sets_flags_i, carry_i} <= v;
      #1;
      if (primed) check({valid_o, flexible_second_operand_o, carry_o, carry_updated_o});
      primed = 1'b1;
      want = {valid_i, model()};
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      for (k = 0; k < 3000; k = k + 1)
      begin
         r = {$random(seed), $random(seed)};
         apply(r[59:0]);
      end
      $display("random test done");
      apply({12'h800, 5'h00, 32'h80000001, 3'h2, 6'h20, 2'h2});
      apply({12'h800, 5'h00, 32'h00000001, 3'h0, 6'h20, 2'h2});
      apply({12'h800, 5'h00, 32'h80000001, 3'h3, 6'h20, 2'h2});
      apply({12'h8FF, 5'h00, 32'h00000000, 3'h4, 6'h00, 2'h3});
      apply({12'h800, 5'h00, 32'hFFFFFFFF, 3'h1, 6'h21, 2'h3});
      apply({12'h800, 5'h00, 32'h12345678, 3'h0, 6'h00, 2'h3});
      apply({12'hC80, 5'h18, 32'h00000000, 3'h0, 6'h00, 2'h2});
      apply({12'hCFF, 5'h00, 32'h00000000, 3'h0, 6'h00, 2'h3});
      apply({12'hFA5, 5'h00, 32'h00000000, 3'h0, 6'h00, 2'h2});
      apply(60'h0);
      $display("corner test done");
      complete_run;
   end
endmodule
bind second_operand_shifter second_operand_shifter_asserts i_chk
(
   .ref_clk_i                 (ref_clk_i),
   .rst_i                     (rst_i),
   .valid_i                   (valid_i),
   .use_imm_i                 (use_imm_i),
   .imm_form_i                (imm_form_i),
   .imm_byte_i                (imm_byte_i),
   .imm_pos_i                 (imm_pos_i),
   .shift_source_register_i   (shift_source_register_i),
   .shift_type_i              (shift_type_i),
   .shift_len_i               (shift_len_i),
   .sets_flags_i              (sets_flags_i),
   .carry_i                   (carry_i),
   .valid_o                   (valid_o),
   .flexible_second_operand_o (flexible_second_operand_o),
   .carry_o                   (carry_o),
   .carry_updated_o           (carry_updated_o)
);
